// File: hdl/smf_pkg.sv
// Package with the constants, layouts and types of the message format block.
package smf_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_CFG        = 8'h00;
  localparam logic [7:0] OFF_CTRL       = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFF_LAST_FRAME = 8'h14;
  // Layout of the nonvolatile configuration word.
  localparam int CFG_W          = 19;
  localparam int POS_MODE       = 0;
  localparam int POS_SVD        = 2;
  localparam int POS_AZE        = 3;
  localparam int POS_WIDTH      = 4;
  localparam int POS_SYNC       = 5;
  localparam int POS_ERC        = 6;
  localparam int POS_DEP        = 7;
  localparam int POS_USER       = 8;
  localparam int POS_RANGE      = 16;
  localparam int POS_PROGRAMMED = 19;
  // Interrupt status bits.
  localparam int IRQ_SENT    = 0;
  localparam int IRQ_CFG_ERR = 1;
  localparam int IRQ_NORMAL  = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Message timing.
  localparam int MSG_PERIOD_NS = 228000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MSG_PERIOD_CYC = MSG_PERIOD_NS / CLK_PERIOD_NS;
  // Phase lengths in messages.
  localparam int SELFTEST_MSGS = 4;
  localparam int AUTOZERO_MSGS = 4;
  // Device data item counts per mode.
  localparam logic [3:0] ITEMS_FULL  = 4'h8;
  localparam logic [3:0] ITEMS_RANGE = 4'h1;
  localparam logic [3:0] ITEMS_CODED = 4'h6;
  // Codes and reduced data range limits.
  localparam logic [9:0] CFG_ERROR_CODE = 10'h3FF;
  localparam logic [9:0] REDUCED_MIN    = 10'h010;
  localparam logic [9:0] REDUCED_MAX    = 10'h3EF;

  typedef enum logic [1:0] {
    SMF_MODE_FULL  = 2'h0,
    SMF_MODE_RANGE = 2'h1,
    SMF_MODE_CODE8 = 2'h2,
    SMF_MODE_CODE10 = 2'h3
  } smf_mode_t;

  typedef enum logic [2:0] {
    SMF_IDLE     = 3'h0,
    SMF_DEVDATA  = 3'h1,
    SMF_SELFTEST = 3'h3,
    SMF_AUTOZERO = 3'h2,
    SMF_NORMAL   = 3'h6,
    SMF_CFGERR   = 3'h4
  } smf_phase_t;
endpackage

// File: hdl/smf_chk_if.sv
// Interface between the message builder and its error check generator.
`timescale 1ns/1ps
interface smf_chk_if;
  logic [11:0] payload;
  logic        parity_mode;
  logic [2:0]  check;
  modport src (output payload, output parity_mode, input check);
  modport chk (input payload, input parity_mode, output check);
endinterface

// File: hdl/smf_check.sv
// Error check generator: three-bit CRC or a single even parity bit.
`timescale 1ns/1ps
module smf_check (
  smf_chk_if.chk ch
);
  logic [2:0] crc;

  // Payload is shifted in most significant bit first from a zero start.
  always_comb
  begin
    crc = 3'h0;
    for (int i = 11; i >= 0; i--)
    begin
      crc = {crc[1], crc[0] ^ crc[2] ^ ch.payload[i], crc[2] ^ ch.payload[i]};
    end
  end

  // The parity bit makes the whole transmitted frame even.
  assign ch.check = ch.parity_mode ? {2'h0, ^ch.payload} : crc;
endmodule

// File: hdl/smf_timer.sv
// Free running message period timer.
`timescale 1ns/1ps
module smf_timer #(
  parameter int PERIOD = smf_pkg::MSG_PERIOD_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      tick
);
  logic [$clog2(PERIOD)-1:0] count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      count <= '0;
    end
    else if (count == ($clog2(PERIOD))'(PERIOD - 1))
    begin
      count <= '0;
    end
    else
    begin
      count <= count + 1'b1;
    end
  end

  assign tick = run && (count == ($clog2(PERIOD))'(PERIOD - 1));
endmodule

// File: hdl/smf_top.sv
// Message format configuration and frame builder with its AXI4-Lite registers.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module smf_top #(
  parameter int MSG_PERIOD = smf_pkg::MSG_PERIOD_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [smf_pkg::CFG_W-1:0] otp_word,
  input  wire logic                      otp_programmed,
  input  wire logic [31:0]               serial_number,
  input  wire logic [9:0]                sensor_sample,
  input  wire logic                      sync_pulse,
  output logic                           msg_valid,
  output logic [16:0]                    msg_frame,
  output logic                           config_programmed_flag,
  output logic                           irq
);
  logic [smf_pkg::CFG_W-1:0] cfg;
  logic                      cfg_loaded;
  logic                      run;
  logic [2:0]                irq_status;
  logic [2:0]                irq_mask;
  smf_pkg::smf_phase_t       phase;
  smf_pkg::smf_phase_t       next_phase;
  logic [3:0]                item;
  logic [3:0]                item_count;
  logic [3:0]                phase_msgs;
  logic                      timer_tick;
  logic                      trigger;
  logic                      cfg_error;
  logic                      reduced_range;
  logic [9:0]                next_data;
  logic [9:0]                clamped;
  logic [7:0]                dev_byte;
  logic [1:0]                state_vec;
  logic                      last_of_phase;
  logic [7:0]                aw_addr;
  logic                      aw_held;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  logic                      w_held;
  logic                      rd_take;
  logic                      wr_do;
  logic [31:0]               rd_value;
  logic                      rd_hit;

  // Decoded configuration fields.
  smf_pkg::smf_mode_t device_data_mode_sel;
  logic               state_vector_disable;
  logic               auto_zero_enable;
  logic               sensor_width_sel;
  logic               sync_pulse_enable;
  logic               error_check_sel;
  logic               config_data_dependent_bit;
  logic [7:0]         user_byte;
  logic [2:0]         range_code;

  smf_chk_if chk_bus ();

  smf_check u_check (
    .ch (chk_bus)
  );

  smf_timer #(
    .PERIOD (MSG_PERIOD)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run && !sync_pulse_enable && phase != smf_pkg::SMF_IDLE),
    .tick    (timer_tick)
  );

  // The word is caught one clock after reset release and never again.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg        <= '0;
      cfg_loaded <= 1'b0;
      config_programmed_flag <= 1'b0;
    end
    else if (!cfg_loaded)
    begin
      cfg        <= otp_word;
      cfg_loaded <= 1'b1;
      config_programmed_flag <= otp_programmed;
    end
  end

  assign device_data_mode_sel = smf_pkg::smf_mode_t'(cfg[smf_pkg::POS_MODE +: 2]);
  assign state_vector_disable      = cfg[smf_pkg::POS_SVD];
  assign auto_zero_enable          = cfg[smf_pkg::POS_AZE];
  assign sensor_width_sel          = cfg[smf_pkg::POS_WIDTH];
  assign sync_pulse_enable         = cfg[smf_pkg::POS_SYNC];
  assign error_check_sel           = cfg[smf_pkg::POS_ERC];
  assign config_data_dependent_bit = cfg[smf_pkg::POS_DEP];
  assign user_byte                 = cfg[smf_pkg::POS_USER +: 8];
  assign range_code                = cfg[smf_pkg::POS_RANGE +: 3];

  // Mode 0 has no reduced form when the state vector is off.
  assign cfg_error =
    (device_data_mode_sel == smf_pkg::SMF_MODE_CODE10 && sensor_width_sel) ||
    (device_data_mode_sel == smf_pkg::SMF_MODE_FULL && state_vector_disable);
  assign reduced_range = state_vector_disable || auto_zero_enable;

  // A sync pulse outside an active phase is simply dropped.
  assign trigger = run && phase != smf_pkg::SMF_IDLE &&
                   (sync_pulse_enable ? sync_pulse : timer_tick);

  always_comb
  begin
    unique case (device_data_mode_sel)
      smf_pkg::SMF_MODE_FULL:  item_count = smf_pkg::ITEMS_FULL;
      smf_pkg::SMF_MODE_RANGE: item_count = smf_pkg::ITEMS_RANGE;
      smf_pkg::SMF_MODE_CODE8,
      smf_pkg::SMF_MODE_CODE10: item_count = smf_pkg::ITEMS_CODED;
    endcase
  end

  // Device data items; coded modes carry user byte, serial number and range.
  always_comb
  begin
    dev_byte = 8'h00;
    if (device_data_mode_sel == smf_pkg::SMF_MODE_RANGE)
    begin
      dev_byte = {5'h00, range_code};
    end
    else if (device_data_mode_sel == smf_pkg::SMF_MODE_FULL)
    begin
      unique case (item)
        4'h0:    dev_byte = cfg[7:0];
        4'h1:    dev_byte = user_byte;
        4'h2:    dev_byte = serial_number[31:24];
        4'h3:    dev_byte = serial_number[23:16];
        4'h4:    dev_byte = serial_number[15:8];
        4'h5:    dev_byte = serial_number[7:0];
        4'h6:    dev_byte = {5'h00, range_code};
        default: dev_byte = {7'h00, config_programmed_flag};
      endcase
    end
    else
    begin
      unique case (item)
        4'h0:    dev_byte = user_byte;
        4'h1:    dev_byte = serial_number[31:24];
        4'h2:    dev_byte = serial_number[23:16];
        4'h3:    dev_byte = serial_number[15:8];
        4'h4:    dev_byte = serial_number[7:0];
        default: dev_byte = {5'h00, range_code};
      endcase
    end
  end

  // Reduced range keeps the extreme codes free for status signalling.
  always_comb
  begin
    clamped = sensor_sample;
    if (reduced_range && sensor_sample < smf_pkg::REDUCED_MIN)
    begin
      clamped = smf_pkg::REDUCED_MIN;
    end
    else if (reduced_range && sensor_sample > smf_pkg::REDUCED_MAX)
    begin
      clamped = smf_pkg::REDUCED_MAX;
    end
  end

  always_comb
  begin
    next_data = 10'h000;
    if (phase == smf_pkg::SMF_CFGERR)
    begin
      next_data = smf_pkg::CFG_ERROR_CODE;
    end
    else if (phase == smf_pkg::SMF_DEVDATA)
    begin
      if (device_data_mode_sel == smf_pkg::SMF_MODE_CODE10)
      begin
        next_data = {2'h0, dev_byte};
      end
      else if (!sensor_width_sel)
      begin
        next_data = {dev_byte, 2'h0};
      end
      else
      begin
        next_data = {2'h0, dev_byte};
      end
    end
    else if (sensor_width_sel)
    begin
      next_data = {2'h0, clamped[9:2]};
    end
    else
    begin
      next_data = clamped;
    end
  end

  // The state vector field stays zero when disabled.
  assign state_vec = state_vector_disable ? 2'h0 : phase[1:0];
  assign chk_bus.payload     = {state_vec, next_data};
  assign chk_bus.parity_mode = error_check_sel;

  always_comb
  begin
    last_of_phase = 1'b0;
    unique case (phase)
      smf_pkg::SMF_DEVDATA:  last_of_phase = (item == item_count - 4'h1);
      smf_pkg::SMF_SELFTEST: last_of_phase = (phase_msgs == 4'(smf_pkg::SELFTEST_MSGS - 1));
      smf_pkg::SMF_AUTOZERO: last_of_phase = (phase_msgs == 4'(smf_pkg::AUTOZERO_MSGS - 1));
      default:               last_of_phase = 1'b0;
    endcase
  end

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      smf_pkg::SMF_IDLE:
      begin
        if (run && cfg_loaded)
        begin
          next_phase = cfg_error ? smf_pkg::SMF_CFGERR : smf_pkg::SMF_DEVDATA;
        end
      end
      smf_pkg::SMF_DEVDATA:
      begin
        if (trigger && last_of_phase)
        begin
          next_phase = smf_pkg::SMF_SELFTEST;
        end
      end
      smf_pkg::SMF_SELFTEST:
      begin
        if (trigger && last_of_phase)
        begin
          next_phase = auto_zero_enable ? smf_pkg::SMF_AUTOZERO : smf_pkg::SMF_NORMAL;
        end
      end
      smf_pkg::SMF_AUTOZERO:
      begin
        if (trigger && last_of_phase)
        begin
          next_phase = smf_pkg::SMF_NORMAL;
        end
      end
      smf_pkg::SMF_NORMAL,
      smf_pkg::SMF_CFGERR: next_phase = phase;
      default:             next_phase = smf_pkg::SMF_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase      <= smf_pkg::SMF_IDLE;
      item       <= 4'h0;
      phase_msgs <= 4'h0;
    end
    else
    begin
      phase <= next_phase;
      if (next_phase != phase)
      begin
        item       <= 4'h0;
        phase_msgs <= 4'h0;
      end
      else if (trigger)
      begin
        item       <= item + 4'h1;
        phase_msgs <= phase_msgs + 4'h1;
      end
    end
  end

  // Frame: state vector, ten data bits, three check bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      msg_valid <= 1'b0;
      msg_frame <= '0;
    end
    else
    begin
      msg_valid <= trigger;
      if (trigger)
      begin
        msg_frame <= {state_vec, next_data, chk_bus.check};
      end
    end
  end

  // AXI4-Lite slave; address and data are accepted in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign wr_do         = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_do)
      begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_do)
      begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= smf_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[7:2] <= smf_pkg::OFF_LAST_FRAME[7:2]) ?
                      smf_pkg::RESP_OKAY : smf_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the low byte lane carries writable bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run      <= 1'b0;
      irq_mask <= smf_pkg::IRQ_MASK_RESET;
    end
    else if (wr_do && w_strb[0])
    begin
      if (aw_addr[7:2] == smf_pkg::OFF_CTRL[7:2])
      begin
        run <= w_data[0];
      end
      if (aw_addr[7:2] == smf_pkg::OFF_IRQ_MASK[7:2])
      begin
        irq_mask <= w_data[2:0];
      end
    end
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    unique case (s_axi_araddr[7:2])
      smf_pkg::OFF_CFG[7:2]:
        rd_value = {12'h000, config_programmed_flag, cfg};
      smf_pkg::OFF_CTRL[7:2]:       rd_value = {31'h0, run};
      smf_pkg::OFF_STATUS[7:2]:
        rd_value = {20'h0, item, 1'b0, cfg_error, reduced_range, cfg_loaded, 1'b0, phase};
      smf_pkg::OFF_IRQ_STATUS[7:2]: rd_value = {29'h0, irq_status};
      smf_pkg::OFF_IRQ_MASK[7:2]:   rd_value = {29'h0, irq_mask};
      smf_pkg::OFF_LAST_FRAME[7:2]: rd_value = {15'h0, msg_frame};
      default:                      rd_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= smf_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_hit ? smf_pkg::RESP_OKAY : smf_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky events; a new event in the clearing read's cycle survives it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status <= 3'h0;
    end
    else
    begin
      irq_status <= (rd_take && s_axi_araddr[7:2] == smf_pkg::OFF_IRQ_STATUS[7:2]) ?
                    3'h0 : irq_status;
      if (trigger)
      begin
        irq_status[smf_pkg::IRQ_SENT] <= 1'b1;
      end
      if (next_phase == smf_pkg::SMF_CFGERR && phase != smf_pkg::SMF_CFGERR)
      begin
        irq_status[smf_pkg::IRQ_CFG_ERR] <= 1'b1;
      end
      if (next_phase == smf_pkg::SMF_NORMAL && phase != smf_pkg::SMF_NORMAL)
      begin
        irq_status[smf_pkg::IRQ_NORMAL] <= 1'b1;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // The data dependent bit is carried in the configuration byte of mode 0 only.
  logic unused_dep;
  assign unused_dep = config_data_dependent_bit;
endmodule

// File: sim/smf_top_assertions.sv
// Checker with the concurrent assertions of the message format block.
`timescale 1ns/1ps
module smf_top_assertions #(
  parameter int MSG_PERIOD = smf_pkg::MSG_PERIOD_CYC
) (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [smf_pkg::CFG_W-1:0] otp_word,
  input wire logic                      otp_programmed,
  input wire logic                      sync_pulse,
  input wire logic                      msg_valid,
  input wire logic [16:0]               msg_frame,
  input wire logic                      config_programmed_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic                      armed;
  logic [smf_pkg::CFG_W-1:0] cfg;
  logic                      cprog;
  logic                      seen;
  int                        gap;
  // The checker keeps its own copy of the configuration, taken on the same edge as the design.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      armed <= 1'b0;
    else if (!armed)
    begin
      armed <= 1'b1;
      cfg   <= otp_word;
      cprog <= otp_programmed;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seen <= 1'b0;
    else if (msg_valid)
      seen <= 1'b1;
    gap <= (!aresetn || msg_valid) ? 0 : gap + 1;
  end
  chk_msg_single: assert property (msg_valid |=> !msg_valid)
    else $error("message strobe longer than one cycle");
  chk_timer_period: assert property (armed && !cfg[5] && seen && msg_valid |->
    gap == MSG_PERIOD-1)
    else $error("timer message period wrong");
  chk_sync_cause: assert property (armed && cfg[5] && msg_valid |-> $past(sync_pulse))
    else $error("message without sync pulse");
  chk_prog_flag: assert property (armed |-> config_programmed_flag == cprog)
    else $error("programmed flag wrong");
  chk_even_parity: assert property (armed && cfg[6] && msg_valid |->
    !(^msg_frame) && msg_frame[2:1] == 2'h0)
    else $error("parity message not even");
  chk_error_code: assert property (armed && cfg[1:0] == 2'h3 && cfg[4] && msg_valid |->
    msg_frame[12:3] == 10'h3FF)
    else $error("configuration error code missing");
  chk_sv_off: assert property (armed && cfg[2] && msg_valid |-> msg_frame[14:13] == 2'h0)
    else $error("state vector sent while disabled");
  chk_dev_align: assert property (armed && msg_valid && !cfg[4] && !cfg[2] &&
    cfg[1:0] != 2'h3 && msg_frame[14:13] == 2'h1 |-> msg_frame[4:3] == 2'h0)
    else $error("device data not left aligned");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind smf_top smf_top_assertions #(.MSG_PERIOD(MSG_PERIOD)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .otp_word(otp_word), .otp_programmed(otp_programmed), .sync_pulse(sync_pulse),
  .msg_valid(msg_valid), .msg_frame(msg_frame), .config_programmed_flag(config_programmed_flag));

// File: sim/smf_ctrl_model.sv
// Model of the control module: issues sync pulses and collects messages.
`timescale 1ns/1ps
module smf_ctrl_model (
  input  wire logic        aclk,
  output logic             sync_pulse,
  input  wire logic        msg_valid,
  input  wire logic [16:0] msg_frame
);
  int          msg_count = 0;
  int          gap = 0;
  int          since = 0;
  logic [16:0] last_frame = 17'h00000;
  initial sync_pulse = 1'b0;
  always @(posedge aclk)
  begin
    since <= msg_valid ? 0 : since + 1;
    if (msg_valid)
    begin
      last_frame <= msg_frame;
      gap        <= since + 1;
      msg_count  <= msg_count + 1;
    end
  end
  // One pulse asks for exactly one message.
  task automatic pulse();
    @(posedge aclk);
    sync_pulse <= 1'b1;
    @(posedge aclk);
    sync_pulse <= 1'b0;
  endtask
endmodule

// File: sim/smf_top_tb.sv
// Self-checking testbench of the message format block.
`timescale 1ns/1ps
module smf_top_tb;
  localparam int PER = 20;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [18:0] otp = 19'h0;
  logic        prog = 1'b0;
  logic [9:0]  sample = 10'h000;
  logic        awready, wready, bvalid, arready, rvalid, sync, mvalid, flag, irq;
  logic [1:0]  bresp, rresp, rr;
  logic [16:0] frame, f;
  int          err_total = 0, total_checks = 0, cycles = 0, n0;
  always #12.5 aclk = ~aclk;
  smf_top #(.MSG_PERIOD(PER)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .otp_word(otp), .otp_programmed(prog), .serial_number(32'h1234ABCD),
    .sensor_sample(sample), .sync_pulse(sync), .msg_valid(mvalid), .msg_frame(frame),
    .config_programmed_flag(flag), .irq(irq));
  smf_ctrl_model ctl (.aclk(aclk), .sync_pulse(sync), .msg_valid(mvalid), .msg_frame(frame));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  function automatic logic [2:0] crc3(input logic [11:0] p);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 11; i >= 0; i--)
      c = {c[1:0], 1'b0} ^ ((p[i] ^ c[2]) ? 3'h3 : 3'h0);
    return c;
  endfunction
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh))
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      awvalid <= awvalid && !ta;
      wvalid <= wvalid && !tw;
      ah = ah || ta;
      wh = wh || tw;
    end
    do
    begin
      @(negedge aclk);
      ta = bvalid;
      rr = bresp;
      @(posedge aclk);
    end
    while (!ta);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    while (!t);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    while (!t);
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic [18:0] o, input logic p, input logic [9:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    otp <= o;
    prog <= p;
    sample <= s;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wait_msgs(input int n);
    n0 = ctl.msg_count + n;
    while (ctl.msg_count < n0)
      @(negedge aclk);
  endtask
  // Coded mode 2, ten-bit data, CRC, timer trigger, no auto-zero.
  task automatic test_timer_coded();
    do_reset(19'h2A502, 1'b1, 10'h155);
    check_eq({31'h0, flag}, 32'h1, "programmed flag");
    axi_read(smf_pkg::OFF_CFG, rd, rr);
    check_eq(rd, 32'h000AA502, "config word");
    axi_read(8'h40, rd, rr);
    check_eq({30'h0, rr}, {30'h0, smf_pkg::RESP_SLVERR}, "unmapped response");
    axi_write(smf_pkg::OFF_CTRL, 32'h1);
    check_eq({30'h0, rr}, {30'h0, smf_pkg::RESP_OKAY}, "write response");
    wait_msgs(1);
    f = ctl.last_frame;
    check_eq({22'h0, f[12:3]}, {22'h0, 10'h294}, "user byte aligned");
    check_eq({29'h0, f[2:0]}, {29'h0, crc3(f[14:3])}, "crc");
    wait_msgs(1);
    check_eq(ctl.gap, PER, "message period");
    check_eq({22'h0, ctl.last_frame[12:3]}, {22'h0, 10'h048}, "serial byte");
    wait_msgs(9);
    f = ctl.last_frame;
    check_eq({22'h0, f[12:3]}, {22'h0, 10'h155}, "ten-bit sample");
    check_eq({29'h0, f[2:0]}, {29'h0, crc3(f[14:3])}, "crc normal");
    axi_read(smf_pkg::OFF_STATUS, rd, rr);
    check_eq({29'h0, rd[2:0]}, 32'h6, "normal right after self-test");
  endtask
  // Coded mode 3 with eight-bit data, parity, sync trigger, interrupt path.
  task automatic test_sync_error();
    do_reset(19'h00073, 1'b1, 10'h200);
    n0 = ctl.msg_count;
    axi_write(smf_pkg::OFF_CTRL, 32'h1);
    repeat (3 * PER) @(posedge aclk);
    check_eq(ctl.msg_count, n0, "no message without pulse");
    ctl.pulse();
    repeat (4) @(posedge aclk);
    check_eq(ctl.msg_count, n0 + 1, "one message per pulse");
    f = ctl.last_frame;
    check_eq({22'h0, f[12:3]}, {22'h0, 10'h3FF}, "error code");
    check_eq({31'h0, ^f}, 32'h0, "even parity");
    @(negedge aclk);
    check_eq({31'h0, irq}, 32'h0, "irq masked");
    axi_write(smf_pkg::OFF_IRQ_MASK, 32'h2);
    @(negedge aclk);
    check_eq({31'h0, irq}, 32'h1, "irq raised");
    axi_read(smf_pkg::OFF_IRQ_STATUS, rd, rr);
    check_eq({30'h0, rd[1:0]}, 32'h3, "irq status");
    @(negedge aclk);
    check_eq({31'h0, irq}, 32'h0, "irq cleared by read");
  endtask
  // Range-only mode, state vector off, auto-zero on, eight-bit data, unprogrammed memory.
  task automatic test_reduced();
    do_reset(19'h0001D, 1'b0, 10'h3FC);
    check_eq({31'h0, flag}, 32'h0, "flag unprogrammed");
    axi_write(smf_pkg::OFF_CTRL, 32'h1);
    wait_msgs(8);
    axi_read(smf_pkg::OFF_STATUS, rd, rr);
    check_eq({29'h0, rd[2:0]}, 32'h2, "auto-zero phase");
    wait_msgs(2);
    f = ctl.last_frame;
    check_eq({30'h0, f[14:13]}, 32'h0, "state vector off");
    check_eq({22'h0, f[12:3]}, {22'h0, 10'h0FB}, "eight-bit sample");
    check_eq({29'h0, f[2:0]}, {29'h0, crc3(f[14:3])}, "crc");
    axi_read(smf_pkg::OFF_STATUS, rd, rr);
    check_eq({31'h0, rd[5]}, 32'h1, "reduced range");
  endtask
  initial
  begin
    test_timer_coded();
    test_sync_error();
    test_reduced();
    report_and_stop();
  end
endmodule
